/* hdl/wkms_cfg.svh */
// Purpose: offsets, field positions, reset values and key words
// Assumes: 5-bit register address, 8-bit data
// Notes: included by the design files and the testbench
`ifndef WKMS_CFG_SVH
`define WKMS_CFG_SVH
`define WKMS_ADDR_ANSWER 5'h0A
`define WKMS_ADDR_KEY 5'h0B
`define WKMS_ADDR_MON 5'h0C
`define WKMS_ADDR_RES_MAIN 5'h0D
`define WKMS_ADDR_RES_SENS 5'h0E
`define WKMS_ANSWER_MASK 8'h3F
`define WKMS_MON_MASK 8'h0F
`define WKMS_RES_MAIN_MASK 8'hFF
`define WKMS_RES_SENS_MASK 8'h0F
`define WKMS_RESET_VAL 8'h00
`define WKMS_KEY_FIRST 8'hD3
`define WKMS_KEY_SECOND 8'h33
`define WKMS_KEY_FLASH 8'hCC
`define WKMS_KEY_CONFIG 8'hCD
`define WKMS_KEY_RESTART 8'hCE
`define WKMS_KEY_DISABLE 8'hCF
`define WKMS_MON_MAX_CODE 4'hB
`endif

/* hdl/wkms_pkg.sv */
// Purpose: shared types of the key, monitor and self-test registers
// Assumes: nothing beyond the configuration header
// Notes: constants live in the header as macros
package wkms_pkg;
   typedef logic [4:0] wkms_addr_t;
   typedef logic [7:0] wkms_data_t;
   typedef logic [3:0] wkms_sel_t;
   // Progress through the three-word unlock sequence
   typedef enum logic [1:0] {
      WKMS_WAIT_FIRST,
      WKMS_WAIT_SECOND,
      WKMS_WAIT_ACTION
   } wkms_key_e;
endpackage

/* hdl/wkms_key_seq.sv */
// Purpose: unlock sequence tracker for the secure key register
// Assumes: one i_wr_stb pulse per key word written
// Notes: action outputs are one-cycle pulses from flip-flops
`include "wkms_cfg.svh"
module wkms_key_seq (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_wr_stb,
   input wire wkms_pkg::wkms_data_t i_word,
   output logic o_flash_pulse,
   output logic o_config_pulse,
   output logic o_wd_restart_pulse,
   output logic o_wd_disable_pulse,
   output wkms_pkg::wkms_key_e o_state
);
   import wkms_pkg::*;

   wkms_key_e state_ff, nxt_state;
   logic [3:0] act_ff, nxt_act;

   // Next tracker state; any bad word falls back to the first position
   always_comb begin
      nxt_state = state_ff;
      nxt_act = 4'h0;
      if (i_wr_stb) begin
         case (state_ff)
            WKMS_WAIT_FIRST: begin
               if (i_word == `WKMS_KEY_FIRST) begin // RULE_03
                  nxt_state = WKMS_WAIT_SECOND;
               end
            end
            WKMS_WAIT_SECOND: begin
               if (i_word == `WKMS_KEY_SECOND) begin // RULE_03
                  nxt_state = WKMS_WAIT_ACTION;
               end else begin
                  nxt_state = WKMS_WAIT_FIRST; // RULE_06
               end
            end
            WKMS_WAIT_ACTION: begin
               nxt_state = WKMS_WAIT_FIRST; // RULE_06 RULE_15
               case (i_word)
                  `WKMS_KEY_FLASH: nxt_act = 4'h1; // RULE_04
                  `WKMS_KEY_CONFIG: nxt_act = 4'h2; // RULE_04
                  `WKMS_KEY_RESTART: nxt_act = 4'h4; // RULE_04
                  `WKMS_KEY_DISABLE: nxt_act = 4'h8; // RULE_05
                  default: nxt_act = 4'h0;
               endcase
            end
            default: nxt_state = WKMS_WAIT_FIRST;
         endcase
      end
   end

   // Register state and action pulses
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_ff <= WKMS_WAIT_FIRST;
         act_ff <= 4'h0;
      end else begin
         state_ff <= nxt_state;
         act_ff <= nxt_act;
      end
   end

   assign o_flash_pulse = act_ff[0];
   assign o_config_pulse = act_ff[1];
   assign o_wd_restart_pulse = act_ff[2];
   assign o_wd_disable_pulse = act_ff[3];
   assign o_state = state_ff;

   // A wrong second word drops the tracker back to the start
   a_bad_second_word: assert property ( // RULE_06
      @(posedge i_clk) disable iff (!i_rst_n)
      state_ff == WKMS_WAIT_SECOND && i_wr_stb
      && i_word != `WKMS_KEY_SECOND
      |=> state_ff == WKMS_WAIT_FIRST)
      else $error("bad second word did not reset tracker");
   // Full sequence ending in the restart word yields one restart pulse
   a_restart_after_seq: assert property ( // RULE_04
      @(posedge i_clk) disable iff (!i_rst_n)
      state_ff == WKMS_WAIT_ACTION && i_wr_stb
      && i_word == `WKMS_KEY_RESTART
      |=> o_wd_restart_pulse && !o_flash_pulse && !o_config_pulse
      ##1 !o_wd_restart_pulse)
      else $error("restart pulse wrong");
   // Disable only follows the two lead words
   a_disable_cause: assert property ( // RULE_05
      @(posedge i_clk) disable iff (!i_rst_n)
      o_wd_disable_pulse |-> $past(state_ff) == WKMS_WAIT_ACTION
      && $past(i_wr_stb) && $past(i_word) == `WKMS_KEY_DISABLE)
      else $error("disable pulse without sequence");
   // After the third word the tracker waits for the first again
   a_seq_returns: assert property ( // RULE_15
      @(posedge i_clk) disable iff (!i_rst_n)
      state_ff == WKMS_WAIT_ACTION && i_wr_stb
      |=> state_ff == WKMS_WAIT_FIRST)
      else $error("tracker did not return to start");
   // Correct first word advances the tracker
   a_first_advances: assert property ( // RULE_03
      @(posedge i_clk) disable iff (!i_rst_n)
      state_ff == WKMS_WAIT_FIRST && i_wr_stb
      && i_word == `WKMS_KEY_FIRST
      |=> state_ff == WKMS_WAIT_SECOND)
      else $error("first word did not advance");
endmodule

/* hdl/wkms_regs.sv */
// Purpose: watchdog answer, unlock key, monitor select, self-test results
// Assumes: decoded register strobes from the serial frame logic, same clock
// Notes: self-test events from on-chip logic, no synchroniser needed
`include "wkms_cfg.svh"
// How it works
// RULE_01: Answer register at 0x0A, six-bit read-write field, resets to zero.
// RULE_02: Key register at 0x0B is write-only, one eight-bit word per write.
// RULE_03: Host writes three key words in order, 0xD3 then 0x33; tracked.
// RULE_04: Third word 0xCC flash, 0xCD configuration, 0xCE watchdog restart.
// RULE_05: Third word 0xCF disables the watchdog for debugging.
// RULE_06: Any wrong key word resets the tracker to the first word.
// RULE_07: Monitor select at 0x0C, four-bit read-write field, resets zero.
// RULE_08: Select code picks the observed signal; zero is pre-regulator half.
// RULE_09: Register 0x0D holds eight flags, reset zero, write one clears.
// RULE_10: Bit 7 reads one when the built-in self-test failed.
// RULE_11: Bit 6 reads one when the thermal shutdown self-test failed.
// RULE_12: Bits 5..0 are over/under flags: pre-regulator, mcu rail, gp rail.
// RULE_13: Result register 0x0E bits 3..0 hold sensor rail over/under flags.
// RULE_14: Codes above the last defined one route nothing but stay readable.
// RULE_15: After a full sequence the tracker expects the first word again.
// RULE_16: Unused data bits read zero and ignore writes.
module wkms_regs (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire wkms_pkg::wkms_addr_t i_addr,
   input wire wkms_pkg::wkms_data_t i_wdata,
   input wire logic i_selftest_failed,
   input wire logic i_thermal_test_failed,
   input wire logic i_prereg_over_test_failed,
   input wire logic i_prereg_under_test_failed,
   input wire logic i_mcu_rail_over_test_failed,
   input wire logic i_mcu_rail_under_test_failed,
   input wire logic i_gp_rail_over_test_failed,
   input wire logic i_gp_rail_under_test_failed,
   input wire logic i_sensor_a_over_test_failed,
   input wire logic i_sensor_a_under_test_failed,
   input wire logic i_sensor_b_over_test_failed,
   input wire logic i_sensor_b_under_test_failed,
   output wkms_pkg::wkms_data_t o_rdata,
   output wkms_pkg::wkms_data_t o_answer_field,
   output wkms_pkg::wkms_sel_t o_monitor_sel,
   output logic o_monitor_valid,
   output logic o_flash_pulse,
   output logic o_config_pulse,
   output logic o_wd_restart_pulse,
   output logic o_wd_disable_pulse
);
   import wkms_pkg::*;

   wkms_data_t answer_ff, nxt_answer;
   wkms_data_t mon_ff, nxt_mon;
   wkms_data_t res_main_ff, nxt_res_main;
   wkms_data_t res_sens_ff, nxt_res_sens;
   wkms_data_t rdata_ff, nxt_rdata;
   wkms_data_t main_events;
   wkms_data_t sens_events;
   wkms_key_e key_state;
   logic key_wr;

   // Address match for one register; callers gate it with i_wr_en
   function automatic logic hit(input wkms_addr_t a, input wkms_addr_t r);
      hit = (a == r);
   endfunction

   // Event vectors in register bit order
   assign main_events = {i_selftest_failed, // RULE_10
                         i_thermal_test_failed, // RULE_11
                         i_prereg_over_test_failed, // RULE_12
                         i_prereg_under_test_failed,
                         i_mcu_rail_over_test_failed,
                         i_mcu_rail_under_test_failed,
                         i_gp_rail_over_test_failed,
                         i_gp_rail_under_test_failed};
   assign sens_events = {4'h0, // RULE_13
                         i_sensor_a_over_test_failed,
                         i_sensor_a_under_test_failed,
                         i_sensor_b_over_test_failed,
                         i_sensor_b_under_test_failed};

   assign key_wr = i_wr_en && hit(i_addr, `WKMS_ADDR_KEY); // RULE_02

   // Register next values; a new failure wins over a same-cycle clear
   always_comb begin
      nxt_answer = answer_ff;
      nxt_mon = mon_ff;
      nxt_res_main = res_main_ff;
      nxt_res_sens = res_sens_ff;
      if (i_wr_en && hit(i_addr, `WKMS_ADDR_ANSWER)) begin
         nxt_answer = i_wdata & `WKMS_ANSWER_MASK; // RULE_01 RULE_16
      end
      if (i_wr_en && hit(i_addr, `WKMS_ADDR_MON)) begin
         nxt_mon = i_wdata & `WKMS_MON_MASK; // RULE_07 RULE_16
      end
      if (i_wr_en && hit(i_addr, `WKMS_ADDR_RES_MAIN)) begin
         nxt_res_main = res_main_ff & ~i_wdata; // RULE_09
      end
      if (i_wr_en && hit(i_addr, `WKMS_ADDR_RES_SENS)) begin
         nxt_res_sens = res_sens_ff & ~i_wdata; // RULE_13
      end
      nxt_res_main = (nxt_res_main | main_events) & `WKMS_RES_MAIN_MASK;
      nxt_res_sens = (nxt_res_sens | sens_events) & `WKMS_RES_SENS_MASK;
   end

   // Read data, key register reads as zero since it is write-only
   always_comb begin
      nxt_rdata = rdata_ff;
      if (i_rd_en) begin
         case (i_addr)
            `WKMS_ADDR_ANSWER: nxt_rdata = answer_ff;
            `WKMS_ADDR_MON: nxt_rdata = mon_ff; // RULE_14
            `WKMS_ADDR_RES_MAIN: nxt_rdata = res_main_ff;
            `WKMS_ADDR_RES_SENS: nxt_rdata = res_sens_ff;
            default: nxt_rdata = `WKMS_RESET_VAL; // RULE_02 RULE_16
         endcase
      end
   end

   // Register storage
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         answer_ff <= `WKMS_RESET_VAL;
         mon_ff <= `WKMS_RESET_VAL;
         res_main_ff <= `WKMS_RESET_VAL;
         res_sens_ff <= `WKMS_RESET_VAL;
         rdata_ff <= `WKMS_RESET_VAL;
      end else begin
         answer_ff <= nxt_answer;
         mon_ff <= nxt_mon;
         res_main_ff <= nxt_res_main;
         res_sens_ff <= nxt_res_sens;
         rdata_ff <= nxt_rdata;
      end
   end

   // Sequence tracker kept apart so the key path stays small
   wkms_key_seq u_key_seq (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_wr_stb(key_wr), // RULE_03 RULE_06
      .i_word(i_wdata),
      .o_flash_pulse(o_flash_pulse), // RULE_04
      .o_config_pulse(o_config_pulse), // RULE_04
      .o_wd_restart_pulse(o_wd_restart_pulse), // RULE_04
      .o_wd_disable_pulse(o_wd_disable_pulse), // RULE_05
      .o_state(key_state) // RULE_15
   );

   assign o_rdata = rdata_ff;
   assign o_answer_field = answer_ff;
   // Code zero routes the pre-regulator at half scale to the analog mux
   assign o_monitor_sel = mon_ff[3:0]; // RULE_08
   // Reserved codes flag the analog path to route nothing
   assign o_monitor_valid = (mon_ff[3:0] <= `WKMS_MON_MAX_CODE); // RULE_14

   // Answer write lands in the low six bits only
   a_answer_write: assert property ( // RULE_01
      @(posedge i_clk) disable iff (!i_rst_n)
      i_wr_en && i_addr == `WKMS_ADDR_ANSWER
      |=> o_answer_field == ($past(i_wdata) & 8'h3F))
      else $error("answer field mismatch");
   // Without a write the answer holds its value
   a_answer_hold: assert property ( // RULE_01
      @(posedge i_clk) disable iff (!i_rst_n)
      !(i_wr_en && i_addr == `WKMS_ADDR_ANSWER)
      |=> $stable(o_answer_field))
      else $error("answer changed without write");
   // Monitor select keeps four bits and upper bits stay zero
   a_monitor_write: assert property ( // RULE_07
      @(posedge i_clk) disable iff (!i_rst_n)
      i_wr_en && i_addr == `WKMS_ADDR_MON
      |=> mon_ff == {4'h0, $past(i_wdata[3:0])})
      else $error("monitor select mismatch");
   // Reserved codes report no routed signal
   a_monitor_reserved: assert property ( // RULE_14
      @(posedge i_clk) disable iff (!i_rst_n)
      o_monitor_valid == (o_monitor_sel < 4'hC))
      else $error("reserved code routed");
   // Stored code reads back, reserved ones included
   a_monitor_readback: assert property ( // RULE_14
      @(posedge i_clk) disable iff (!i_rst_n)
      i_rd_en && i_addr == `WKMS_ADDR_MON
      |=> o_rdata == {4'h0, $past(o_monitor_sel)})
      else $error("monitor select not readable");
   // A failure event sets its flag even while being cleared
   a_flag_set_wins: assert property ( // RULE_10
      @(posedge i_clk) disable iff (!i_rst_n)
      i_selftest_failed |=> res_main_ff[7])
      else $error("self-test flag lost");
   // Every main event sets its own flag a cycle later
   a_main_events_set: assert property ( // RULE_12
      @(posedge i_clk) disable iff (!i_rst_n)
      main_events != 8'h00
      |=> (res_main_ff & $past(main_events)) == $past(main_events))
      else $error("main flag not set by its event");
   // A main flag only rises on its own event
   a_main_no_spurious: assert property ( // RULE_09
      @(posedge i_clk) disable iff (!i_rst_n)
      1'h1 |=> (res_main_ff & ~$past(res_main_ff)
      & ~$past(main_events)) == 8'h00)
      else $error("main flag set without event");
   // Writing one clears a flag when no event is present
   a_flag_clear: assert property ( // RULE_11
      @(posedge i_clk) disable iff (!i_rst_n)
      i_wr_en && i_addr == `WKMS_ADDR_RES_MAIN && i_wdata[6]
      && !i_thermal_test_failed |=> !res_main_ff[6])
      else $error("thermal flag not cleared");
   // Sensor flags clear the same way
   a_sens_clear: assert property ( // RULE_13
      @(posedge i_clk) disable iff (!i_rst_n)
      i_wr_en && i_addr == `WKMS_ADDR_RES_SENS && i_wdata[0]
      && !i_sensor_b_under_test_failed |=> !res_sens_ff[0])
      else $error("sensor flag not cleared");
   // Every sensor event sets its own flag a cycle later
   a_sens_events_set: assert property ( // RULE_13
      @(posedge i_clk) disable iff (!i_rst_n)
      sens_events != 8'h00
      |=> (res_sens_ff & $past(sens_events)) == $past(sens_events))
      else $error("sensor flag not set by its event");
   // A sensor flag only rises on its own event
   a_sens_no_spurious: assert property ( // RULE_13
      @(posedge i_clk) disable iff (!i_rst_n)
      1'h1 |=> (res_sens_ff & ~$past(res_sens_ff)
      & ~$past(sens_events)) == 8'h00)
      else $error("sensor flag set without event");
   // Sensor register upper nibble never sets
   a_sensor_upper: assert property ( // RULE_16
      @(posedge i_clk) disable iff (!i_rst_n)
      res_sens_ff[7:4] == 4'h0)
      else $error("sensor upper bits set");
   // Key register reads back as zero
   a_key_reads_zero: assert property ( // RULE_02
      @(posedge i_clk) disable iff (!i_rst_n)
      i_rd_en && i_addr == `WKMS_ADDR_KEY |=> o_rdata == 8'h00)
      else $error("key register readable");
   // Writes elsewhere leave the unlock tracker where it was
   a_key_undisturbed: assert property ( // RULE_03
      @(posedge i_clk) disable iff (!i_rst_n)
      i_wr_en && i_addr != `WKMS_ADDR_KEY |=> $stable(key_state))
      else $error("tracker moved on another write");
   // A third word outside the four actions gives no pulse
   a_wrong_third_quiet: assert property ( // RULE_06
      @(posedge i_clk) disable iff (!i_rst_n)
      key_state == WKMS_WAIT_ACTION && key_wr
      && (i_wdata < `WKMS_KEY_FLASH || i_wdata > `WKMS_KEY_DISABLE)
      |=> !o_flash_pulse && !o_config_pulse
      && !o_wd_restart_pulse && !o_wd_disable_pulse)
      else $error("pulse after wrong third word");
endmodule

/* verif/wkms_host_model.sv */
// Purpose: host side of the register strobes, reads and writes
// Assumes: one access at a time, driven on falling edges
// Notes: released address and data show the inverse of the last value
module wkms_host_model (
   input wire logic i_clk,
   output logic o_wr_en,
   output logic o_rd_en,
   output wkms_pkg::wkms_addr_t o_addr,
   output wkms_pkg::wkms_data_t o_wdata,
   input wire wkms_pkg::wkms_data_t i_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   import wkms_pkg::*;

   // Idle bus at time zero
   initial begin
      o_wr_en = 1'b0;
      o_rd_en = 1'b0;
      o_addr = 5'h00;
      o_wdata = 8'h00;
   end

   // One write, held across the taking edge, then released
   task automatic wr(input wkms_addr_t a, input wkms_data_t d);
      @(negedge i_clk);
      o_wr_en = 1'b1;
      o_addr = a;
      o_wdata = d;
      @(negedge i_clk);
      o_wr_en = 1'b0;
      o_addr = ~a;
      o_wdata = ~d;
   endtask

   // Read data is registered, so it is taken one edge later
   task automatic rd(input wkms_addr_t a, output wkms_data_t d);
      @(negedge i_clk);
      o_rd_en = 1'b1;
      o_addr = a;
      @(negedge i_clk);
      d = i_rdata;
      o_rd_en = 1'b0;
      o_addr = ~a;
   endtask
endmodule

/* verif/tb.sv */
// Purpose: register, unlock and self-test checks of the register bank
// Assumes: host model drives strobes, bench drives the self-test events
// Notes: key words are sent one write apart, not back to back
`include "wkms_cfg.svh"
module tb import wkms_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic wr_en;
   logic rd_en;
   wkms_addr_t addr;
   wkms_data_t wdata;
   wkms_data_t rdata;
   wkms_data_t answer;
   wkms_data_t got;
   wkms_sel_t sel;
   logic mon_valid;
   logic [3:0] act;
   logic [11:0] ev = 12'h000;
   logic [11:0] v;
   int error_cnt = 0;
   int samples_checked = 0;

   // Clock of 25 ns
   always #12.5 i_clk = ~i_clk;

   wkms_host_model HOST (.i_clk(i_clk), .o_wr_en(wr_en), .o_rd_en(rd_en),
      .o_addr(addr), .o_wdata(wdata), .i_rdata(rdata));

   wkms_regs DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wr_en(wr_en),
      .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata),
      .i_selftest_failed(ev[11]), .i_thermal_test_failed(ev[10]),
      .i_prereg_over_test_failed(ev[9]), .i_prereg_under_test_failed(ev[8]),
      .i_mcu_rail_over_test_failed(ev[7]),
      .i_mcu_rail_under_test_failed(ev[6]),
      .i_gp_rail_over_test_failed(ev[5]), .i_gp_rail_under_test_failed(ev[4]),
      .i_sensor_a_over_test_failed(ev[3]),
      .i_sensor_a_under_test_failed(ev[2]),
      .i_sensor_b_over_test_failed(ev[1]),
      .i_sensor_b_under_test_failed(ev[0]),
      .o_rdata(rdata), .o_answer_field(answer), .o_monitor_sel(sel),
      .o_monitor_valid(mon_valid), .o_flash_pulse(act[3]),
      .o_config_pulse(act[2]), .o_wd_restart_pulse(act[1]),
      .o_wd_disable_pulse(act[0]));

   // Count and report one comparison
   task automatic chk(input string n, input logic [7:0] e,
      input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic rd_chk(input wkms_addr_t a, input wkms_data_t e,
      input string n);
      HOST.rd(a, got);
      chk(n, e, got);
   endtask

   // Three key words, then the action pulse and its end one cycle later
   task automatic key_seq(input wkms_data_t w1, input wkms_data_t w2,
      input wkms_data_t w3, input logic [3:0] e);
      HOST.wr(`WKMS_ADDR_KEY, w1);
      HOST.wr(`WKMS_ADDR_KEY, w2);
      HOST.wr(`WKMS_ADDR_KEY, w3);
      chk("action", {4'h0, e}, {4'h0, act});
      @(negedge i_clk);
      chk("action_end", 8'h00, {4'h0, act});
   endtask

   // One-cycle self-test events
   task automatic ev_pulse(input logic [11:0] p);
      @(negedge i_clk);
      ev = p;
      @(negedge i_clk);
      ev = 12'h000;
   endtask

   task automatic summarize;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (12) @(negedge i_clk);
      i_rst_n = 1'b1;
      rd_chk(`WKMS_ADDR_ANSWER, 8'h00, "answer_rst");
      rd_chk(`WKMS_ADDR_MON, 8'h00, "mon_rst");
      rd_chk(`WKMS_ADDR_RES_MAIN, 8'h00, "main_rst");
      rd_chk(`WKMS_ADDR_RES_SENS, 8'h00, "sens_rst");
      chk("mon_valid_rst", 8'h01, {7'h00, mon_valid});
      HOST.wr(`WKMS_ADDR_ANSWER, 8'hFF);
      rd_chk(`WKMS_ADDR_ANSWER, 8'h3F, "answer");
      chk("answer_out", 8'h3F, answer);
      HOST.wr(5'h1F, 8'hFF);
      rd_chk(5'h1F, 8'h00, "unmapped");
      HOST.wr(`WKMS_ADDR_MON, 8'hFB);
      rd_chk(`WKMS_ADDR_MON, 8'h0B, "mon_top");
      chk("mon_valid_top", 8'h01, {7'h00, mon_valid});
      HOST.wr(`WKMS_ADDR_MON, 8'h0C);
      rd_chk(`WKMS_ADDR_MON, 8'h0C, "mon_resv");
      chk("mon_valid_resv", 8'h00, {7'h00, mon_valid});
      chk("mon_sel", 8'h0C, {4'h0, sel});
      // Every action word, sequences with idle cycles between them
      key_seq(8'hD3, 8'h33, 8'hCC, 4'h8);
      key_seq(8'hD3, 8'h33, 8'hCD, 4'h4);
      key_seq(8'hD3, 8'h33, 8'hCE, 4'h2);
      key_seq(8'hD3, 8'h33, 8'hCF, 4'h1);
      rd_chk(`WKMS_ADDR_KEY, 8'h00, "key_wo");
      key_seq(8'hD3, 8'h00, 8'hCC, 4'h0);
      key_seq(8'hD3, 8'h33, 8'hCB, 4'h0);
      key_seq(8'hD3, 8'h33, 8'hCE, 4'h2);
      // Each flag alone, at its own bit position
      for (int i = 0; i < 12; i++) begin
         v = 12'h001 << i;
         ev_pulse(v);
         HOST.rd(`WKMS_ADDR_RES_MAIN, got);
         chk("main_bit", v[11:4], got);
         rd_chk(`WKMS_ADDR_RES_SENS, {4'h0, v[3:0]}, "sens_bit");
         HOST.wr(`WKMS_ADDR_RES_MAIN, 8'hFF);
         HOST.wr(`WKMS_ADDR_RES_SENS, 8'hFF);
      end
      // Partial clears leave the other flags standing
      ev_pulse(12'hFFF);
      HOST.wr(`WKMS_ADDR_RES_MAIN, 8'h81);
      rd_chk(`WKMS_ADDR_RES_MAIN, 8'h7E, "main_w1c");
      HOST.wr(`WKMS_ADDR_RES_SENS, 8'hF5);
      rd_chk(`WKMS_ADDR_RES_SENS, 8'h0A, "sens_w1c");
      // Failure in the same cycle as its clear keeps the flag set
      fork
         ev_pulse(12'hC00);
         HOST.wr(`WKMS_ADDR_RES_MAIN, 8'hFF);
      join
      rd_chk(`WKMS_ADDR_RES_MAIN, 8'hC0, "main_set_wins");
      summarize;
   end

   // Hang guard, well beyond the few hundred cycles of the sequence
   initial begin
      repeat (5000) @(posedge i_clk);
      error_cnt++;
      $display("CHECK FAILED watchdog expected done seen timeout");
      summarize;
   end
endmodule
